// [hdl/pbsi_pkg.sv]
// Purpose: shared constants and carrier types of the burst sram interface
// Assumes: x36 organisation, four lanes of eight data bits plus one parity bit
// Notes:   all widths fixed; memory is modelled inside the core
package pbsi_pkg;

    localparam int ADDR_W = 19;
    localparam int LANES  = 4;
    localparam int DATA_W = 32;
    localparam int WORD_W = 36;
    localparam int DEPTH  = 524288;

    // field positions inside a stored word: data low, parity on top
    localparam int LANE_DATA_W = 8;
    localparam int PARITY_LSB  = 32;

    // reset values
    localparam logic [1:0]        CNT_RST  = 2'h0;
    localparam logic [ADDR_W-3:0] BASE_RST = 17'h00000;
    localparam logic [3:0]        MASK_OFF = 4'h0;
    localparam logic [3:0]        MASK_ALL = 4'hF;

    // async pins travel together through the synchroniser
    typedef struct packed {
        logic oe_n;
        logic sleep;
        logic order;
    } pbsi_async_t;

    // idle pins: output disabled, awake, interleaved (strap pulled up)
    localparam pbsi_async_t ASYNC_RST = pbsi_async_t'(3'h5);

    typedef struct packed {
        logic       all_n;
        logic       gate_n;
        logic [3:0] lane_n;
    } pbsi_wr_t;

    typedef enum logic [1:0] {
        PBSI_DESEL,
        PBSI_ACTIVE,
        PBSI_SLEEP
    } pbsi_state_t;

endpackage : pbsi_pkg

// [hdl/pbsi_core.sv]
// Purpose: device-side control of a pipelined burst sram with its array
// Assumes: strobes, selects and data are synchronous to core_clk_i
// Notes:   output enable, sleep and burst order pins are resynchronised
// Operation
// - capture all synchronous inputs on the rising clock edge
// - low advance during a burst steps the burst counter
// - selected only when select1 low, select2 high, select3 low
// - chip selects evaluated only on address load cycles
// - accepted strobe loads full address and low two bits into counter
// - both strobes low with select1 low: processor strobe wins, controller strobe ignored
// - output enable low drives data pins, high tristates them
// - first read cycle after deselect keeps data pins tristated
// - read data is the location addressed two edges earlier
// - write data and parity captured on the rising edge
// - sleep input high enters low power with contents kept
// - burst order strap low linear, high interleaved
// - counter wraps in four: interleaved xor, linear modulo four
// - global write writes all bytes, else gate plus lane selects
// - deselect keeps outputs one more cycle, then tristates
// - processor strobe write ignores write enables on first cycle
`timescale 1ns/100ps
`default_nettype none

module pbsi_core (
    // clock, reset, enable
    input  wire logic                        core_clk_i,
    input  wire logic                        rst_n_i,
    input  wire logic                        clk_en_i,
    // address and strobes
    input  wire logic [pbsi_pkg::ADDR_W-1:0] addr_i,
    input  wire logic                        processor_strobe_n_i,
    input  wire logic                        controller_strobe_n_i,
    input  wire logic                        burst_step_n_i,
    // chip selects
    input  wire logic                        pipelined_select_n_i,
    input  wire logic                        expansion_select_hi_i,
    input  wire logic                        expansion_select_n_i,
    // write enables
    input  wire logic                        all_bytes_write_n_i,
    input  wire logic                        byte_write_gate_n_i,
    input  wire logic [3:0]                  byte_lane_select_n_i,
    // asynchronous pins
    input  wire logic                        output_enable_n_i,
    input  wire logic                        sleep_request_i,
    input  wire logic                        burst_order_i,
    // data pins
    input  wire logic [pbsi_pkg::DATA_W-1:0] data_i,
    input  wire logic [3:0]                  parity_io_i,
    output logic      [pbsi_pkg::DATA_W-1:0] data_o,
    output logic      [3:0]                  parity_io_o,
    output logic                             data_oe_n_o,
    // status
    output logic                             sleep_o
);

    logic [pbsi_pkg::WORD_W-1:0]   mem [0:pbsi_pkg::DEPTH-1];
    pbsi_pkg::pbsi_async_t         s1_ff;
    pbsi_pkg::pbsi_async_t         s2_ff;
    pbsi_pkg::pbsi_async_t         s3_ff;
    pbsi_pkg::pbsi_async_t         filt_ff;
    pbsi_pkg::pbsi_state_t         state_ff;
    pbsi_pkg::pbsi_wr_t            wr_pins;
    logic [pbsi_pkg::ADDR_W-3:0]   base_ff;
    logic [1:0]                    start_ff;
    logic [1:0]                    step_ff;
    logic [1:0]                    nxt_step;
    logic [pbsi_pkg::WORD_W-1:0]   rd_stage_ff;
    logic                          en_s1_ff;
    logic                          ps_take;
    logic                          cs_take;
    logic                          load;
    logic                          sel;
    logic                          asleep;
    logic                          access;
    logic                          rd_first;
    logic [3:0]                    wr_mask;
    logic [pbsi_pkg::ADDR_W-1:0]   eff_addr;
    logic [pbsi_pkg::WORD_W-1:0]   rd_word;

    function automatic logic [1:0] burst_addr(input logic [1:0] start,
                                              input logic [1:0] step,
                                              input logic       interleave);
        burst_addr = interleave ? (start ^ step) : 2'(start + step);
    endfunction : burst_addr

    function automatic logic [3:0] write_mask(input pbsi_pkg::pbsi_wr_t w);
        if (!w.all_n)
            write_mask = pbsi_pkg::MASK_ALL;
        else if (!w.gate_n)
            write_mask = ~w.lane_n;
        else
            write_mask = pbsi_pkg::MASK_OFF;
    endfunction : write_mask

    // async pins: three stages, a level counts once stages two and three agree
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
            {s1_ff, s2_ff, s3_ff, filt_ff} <= {4{pbsi_pkg::ASYNC_RST}};
        else if (clk_en_i)
        begin
            s1_ff   <= '{oe_n: output_enable_n_i, sleep: sleep_request_i,
                         order: burst_order_i};
            s2_ff   <= s1_ff;
            s3_ff   <= s2_ff;
            // strap is assumed static, so a later change is simply followed
            filt_ff <= (s2_ff & s3_ff) | (filt_ff & (s2_ff ^ s3_ff));
        end
    end

    assign asleep  = filt_ff.sleep;
    assign wr_pins = '{all_n: all_bytes_write_n_i, gate_n: byte_write_gate_n_i,
                       lane_n: byte_lane_select_n_i};

    always_comb
    begin
        ps_take  = !processor_strobe_n_i && !pipelined_select_n_i;
        // an ignored processor strobe leaves the controller strobe in charge
        cs_take  = !controller_strobe_n_i
                   && (processor_strobe_n_i || pipelined_select_n_i);
        load     = (ps_take || cs_take) && !asleep;
        sel      = !pipelined_select_n_i && expansion_select_hi_i
                   && !expansion_select_n_i;
        nxt_step = !burst_step_n_i ? 2'(step_ff + 2'h1) : step_ff;
        access   = 1'b0;
        rd_first = 1'b0;
        wr_mask  = pbsi_pkg::MASK_OFF;
        eff_addr = addr_i;
        if (load && sel)
        begin
            access   = 1'b1;
            rd_first = (state_ff != pbsi_pkg::PBSI_ACTIVE);
            wr_mask  = cs_take ? write_mask(wr_pins) : pbsi_pkg::MASK_OFF;
        end
        else if (!load && !asleep && state_ff == pbsi_pkg::PBSI_ACTIVE)
        begin
            access   = 1'b1;
            wr_mask  = write_mask(wr_pins);
            eff_addr = {base_ff, burst_addr(start_ff, nxt_step, filt_ff.order)};
        end
        rd_word  = mem[eff_addr];
    end

    // select state: only an address load can select; a load or waking from sleep can deselect
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
            state_ff <= pbsi_pkg::PBSI_DESEL;
        else if (clk_en_i)
        begin
            case (state_ff)
                pbsi_pkg::PBSI_SLEEP:
                    if (!asleep)
                        state_ff <= (load && sel) ? pbsi_pkg::PBSI_ACTIVE : pbsi_pkg::PBSI_DESEL;
                default:
                    if (asleep)
                        state_ff <= pbsi_pkg::PBSI_SLEEP;
                    else if (load)
                        state_ff <= sel ? pbsi_pkg::PBSI_ACTIVE
                                        : pbsi_pkg::PBSI_DESEL;
            endcase
        end
    end

    // address register and burst counter
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
            {base_ff, start_ff, step_ff} <= {pbsi_pkg::BASE_RST, pbsi_pkg::CNT_RST, pbsi_pkg::CNT_RST};
        else if (clk_en_i)
        begin
            if (load && sel)
            begin
                base_ff  <= addr_i[pbsi_pkg::ADDR_W-1:2];
                start_ff <= addr_i[1:0];
                step_ff  <= pbsi_pkg::CNT_RST;
            end
            else if (access)
                step_ff  <= nxt_step;
        end
    end

    // array: self-timed write of pin data on the edge, lanes kept apart
    always_ff @(posedge core_clk_i)
    begin
        if (rst_n_i && clk_en_i)
        begin
            for (int k = 0; k < pbsi_pkg::LANES; k++)
            begin
                if (wr_mask[k])
                begin
                    mem[eff_addr][k*pbsi_pkg::LANE_DATA_W +: pbsi_pkg::LANE_DATA_W]
                        <= data_i[k*pbsi_pkg::LANE_DATA_W +: pbsi_pkg::LANE_DATA_W];
                    mem[eff_addr][pbsi_pkg::PARITY_LSB + k] <= parity_io_i[k];
                end
            end
        end
    end

    // read pipe: array to stage on the address edge, stage to pins one edge later
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
            {rd_stage_ff, parity_io_o, data_o} <= {36'h0, pbsi_pkg::MASK_OFF, 32'h0};
        else if (clk_en_i)
        begin
            if (access && wr_mask == pbsi_pkg::MASK_OFF)
                rd_stage_ff <= rd_word;
            {parity_io_o, data_o} <= rd_stage_ff;
        end
    end

    // enable trails the read by one edge: double-cycle deselect for free, oe sync adds latency
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
            {en_s1_ff, data_oe_n_o, sleep_o} <= 3'h2;
        else if (clk_en_i)
        begin
            en_s1_ff    <= access && wr_mask == pbsi_pkg::MASK_OFF;
            data_oe_n_o <= !(en_s1_ff && !filt_ff.oe_n && !asleep
                             && wr_mask == pbsi_pkg::MASK_OFF && !rd_first);
            sleep_o     <= asleep;
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    property p_select;
        clk_en_i && load && sel && !asleep |=> state_ff == pbsi_pkg::PBSI_ACTIVE;
    endproperty
    a_select: assert property (p_select) else $error("selected load not active");
    property p_deselect;
        clk_en_i && load && !sel && !asleep |=> state_ff == pbsi_pkg::PBSI_DESEL;
    endproperty
    a_deselect: assert property (p_deselect) else $error("deselect not taken");
    property p_cont_ignores_sel;
        clk_en_i && !load && !asleep && state_ff == pbsi_pkg::PBSI_ACTIVE
        |=> state_ff == pbsi_pkg::PBSI_ACTIVE;
    endproperty
    a_cont_ignores_sel: assert property (p_cont_ignores_sel) else $error("burst dropped");
    property p_ps_blocked;
        !processor_strobe_n_i && pipelined_select_n_i && controller_strobe_n_i |-> !load;
    endproperty
    a_ps_blocked: assert property (p_ps_blocked) else $error("blocked strobe loaded");
    property p_load_addr;
        clk_en_i && load && sel && !asleep
        |=> base_ff == $past(addr_i[pbsi_pkg::ADDR_W-1:2]) && start_ff == $past(addr_i[1:0])
            && step_ff == pbsi_pkg::CNT_RST;
    endproperty
    a_load_addr: assert property (p_load_addr) else $error("address not loaded");
    property p_ps_no_write;
        ps_take && load |-> wr_mask == pbsi_pkg::MASK_OFF;
    endproperty
    a_ps_no_write: assert property (p_ps_no_write) else $error("first ps cycle wrote");
    property p_step;
        clk_en_i && access && !load && !burst_step_n_i |=> step_ff == 2'($past(step_ff) + 2'h1);
    endproperty
    a_step: assert property (p_step) else $error("counter did not step");
    property p_hold;
        clk_en_i && !load && burst_step_n_i |=> step_ff == $past(step_ff);
    endproperty
    a_hold: assert property (p_hold) else $error("counter moved");
    property p_read_pipe;
        clk_en_i && access && wr_mask == pbsi_pkg::MASK_OFF ##1 clk_en_i
        |=> {parity_io_o, data_o} == $past(rd_word, 2);
    endproperty
    a_read_pipe: assert property (p_read_pipe) else $error("read data wrong");
    property p_first_read_tri;
        clk_en_i && access && rd_first |=> data_oe_n_o;
    endproperty
    a_first_read_tri: assert property (p_first_read_tri) else $error("first read driven");
    property p_oe_off;
        clk_en_i && filt_ff.oe_n |=> data_oe_n_o;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("driven with oe high");
    property p_dcd;
        clk_en_i && en_s1_ff && load && !sel && !asleep && !filt_ff.oe_n
        ##1 clk_en_i |-> !data_oe_n_o ##1 data_oe_n_o;
    endproperty
    a_dcd: assert property (p_dcd) else $error("deselect timing wrong");
    property p_sleep;
        clk_en_i && asleep |=> sleep_o && data_oe_n_o && state_ff == pbsi_pkg::PBSI_SLEEP;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep not entered");

    c_burst_read:  cover property (clk_en_i && access && !load && !burst_step_n_i ##1 !data_oe_n_o);
    c_cs_write:    cover property (clk_en_i && cs_take && sel && wr_mask != pbsi_pkg::MASK_OFF);
    c_ps_write:    cover property (clk_en_i && ps_take && sel ##1 wr_mask != pbsi_pkg::MASK_OFF);
    c_sleep_cycle: cover property (sleep_o ##1 !sleep_o);

endmodule : pbsi_core
`default_nettype wire

// [tb/pbsi_host.sv]
// Purpose: behavioural processor side driving the burst sram bus
// Assumes: one request per clock, pins change 1 ns after the rising edge
// Notes:   released data lines show the inverse of their last value
`timescale 1ns/100ps
`default_nettype none

module pbsi_host (
    // clock and device side of the data pins
    input  wire logic                [35:0] dev_word_i,
    input  wire logic                       dev_oe_n_i,
    input  wire logic                       core_clk_i,
    // bus pins
    output logic                     [18:0] addr_o,
    output logic                            ps_n_o,
    output logic                            cs_n_o,
    output logic                            adv_n_o,
    output logic                     [2:0]  sel_o,
    output var pbsi_pkg::pbsi_wr_t          wr_o,
    output logic                            sleep_req_o,
    // resolved data wire
    output logic                     [35:0] wire_o
);
    logic        drv_ff;
    logic [35:0] wdat_ff;
    logic [35:0] last_ff;

    initial
    begin
        {ps_n_o, cs_n_o, adv_n_o} = 3'h7;
        {addr_o, sel_o, drv_ff, wdat_ff, last_ff} = '0;
        wr_o = pbsi_pkg::pbsi_wr_t'(6'h3F);
        sleep_req_o = 1'b0;
    end

    // released wire toggles so a stale value never reads as a match
    always_comb
    begin
        if (!dev_oe_n_i)
            wire_o = dev_word_i;
        else if (drv_ff)
            wire_o = wdat_ff;
        else
            wire_o = ~last_ff;
    end

    always @(posedge core_clk_i)
        last_ff <= wire_o;

    // one request, held across exactly one rising edge
    task automatic bus(input logic ps, input logic cs, input logic burst_step_n, input logic [2:0] sel,
                       input pbsi_pkg::pbsi_wr_t wr, input logic [18:0] a, input logic [35:0] d);
        {ps_n_o, cs_n_o, adv_n_o, sel_o, addr_o} = {ps, cs, burst_step_n, sel, a};
        wr_o = wr;
        drv_ff = !wr.all_n || !wr.gate_n;
        wdat_ff = d;
        @(posedge core_clk_i);
        #1;
    endtask : bus
endmodule : pbsi_host

`default_nettype wire

// [tb/pipelined_burst_sram_interface_test.sv]
// Purpose: self-checking bench of the burst sram interface against a word model
// Assumes: strap changes only under reset, output enable held low except one test
// Notes:   sleep entry and exit are judged only by the status output
`timescale 1ns/100ps
`default_nettype none

module pipelined_burst_sram_interface_test;
    localparam logic [2:0] SEL_ON = 3'h2;
    localparam pbsi_pkg::pbsi_wr_t WR_NO  = pbsi_pkg::pbsi_wr_t'(6'h3F);
    localparam pbsi_pkg::pbsi_wr_t WR_ALL = pbsi_pkg::pbsi_wr_t'(6'h1F);
    logic               core_clk_i = 1'b0;
    logic               rst_n_i = 1'b0;
    logic               order = 1'b1;
    logic               oe_pin = 1'b0;
    logic        [18:0] addr, base, adr, prev;
    logic               ps_n, cs_n, adv_n, sleep, oe_n, sleep_o;
    logic        [2:0]  sel;
    logic        [35:0] bus_w, d;
    logic        [31:0] data_o, seed = 32'hEF99;
    logic        [3:0]  par_o;
    logic        [1:0]  s, step, nxt;
    logic        [2:0]  bad [3] = '{3'h6, 3'h0, 3'h3};
    pbsi_pkg::pbsi_wr_t wr, w;
    logic        [35:0] mem [int];
    int                 error_cnt = 0;
    int                 total_checks = 0;

    always #10 core_clk_i = ~core_clk_i;

    pbsi_host host (.core_clk_i(core_clk_i), .dev_word_i({par_o, data_o}), .dev_oe_n_i(oe_n),
        .addr_o(addr), .ps_n_o(ps_n), .cs_n_o(cs_n), .adv_n_o(adv_n), .sel_o(sel), .wr_o(wr),
        .sleep_req_o(sleep), .wire_o(bus_w));

    pbsi_core DUT (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .clk_en_i(1'b1), .addr_i(addr),
        .processor_strobe_n_i(ps_n), .controller_strobe_n_i(cs_n), .burst_step_n_i(adv_n),
        .pipelined_select_n_i(sel[2]), .expansion_select_hi_i(sel[1]),
        .expansion_select_n_i(sel[0]), .all_bytes_write_n_i(wr.all_n),
        .byte_write_gate_n_i(wr.gate_n), .byte_lane_select_n_i(wr.lane_n),
        .output_enable_n_i(oe_pin), .sleep_request_i(sleep), .burst_order_i(order),
        .data_i(bus_w[31:0]), .parity_io_i(bus_w[35:32]), .data_o(data_o), .parity_io_o(par_o),
        .data_oe_n_o(oe_n), .sleep_o(sleep_o));

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    task automatic chk(input logic [35:0] e, input logic [35:0] g);
        total_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("mismatch at %0t: expected %h, got %h", $time, e, g);
        end
    endtask : chk

    task automatic rd_out(input logic [18:0] a);
        chk(mem[a], {par_o, data_o});
        chk(36'h0, {35'h0, oe_n});
    endtask : rd_out

    // lane k is eight data bits plus parity bit k
    task automatic put(input logic [18:0] a, input pbsi_pkg::pbsi_wr_t x, input logic [35:0] v);
        logic [35:0] m;
        m = mem.exists(a) ? mem[a] : 36'h0;
        for (int k = 0; k < 4; k++)
            if (!x.all_n || (!x.gate_n && !x.lane_n[k]))
            begin
                m[8*k +: 8] = v[8*k +: 8];
                m[32+k] = v[32+k];
            end
        mem[a] = m;
    endtask : put

    task automatic idle();
        host.bus(1'b1, 1'b1, 1'b1, SEL_ON, WR_NO, 19'h0, 36'h0);
    endtask : idle

    task automatic complete_run();
        $display("checks %0d, mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : complete_run

    initial
    begin
        #2ms;
        error_cnt++;
        complete_run();
    end

    initial
    begin
        #1;
        for (int ph = 0; ph < 2; ph++)
        begin
            // strap only moves while reset holds the device idle
            order = (ph == 0);
            rst_n_i = 1'b0;
            repeat (6) idle();
            rst_n_i = 1'b1;
            repeat (4) idle();
            base = {19'(xs())} & 19'h7FFFC;
            for (int i = 0; i < 4; i++)
            begin
                d = 36'({xs(), xs()});
                host.bus(1'b1, 1'b0, 1'b1, SEL_ON, WR_ALL, base | 19'(i), d);
                put(base | 19'(i), WR_ALL, d);
                chk(36'h1, {35'h0, oe_n});
            end
            s = 2'(xs());
            w = pbsi_pkg::pbsi_wr_t'({2'h2, 4'(xs())});
            d = 36'({xs(), xs()});
            host.bus(1'b0, 1'b1, 1'b1, SEL_ON, WR_ALL, {base[18:2], s}, ~d);
            host.bus(1'b1, 1'b1, 1'b1, 3'h5, w, 19'h0, d);
            put({base[18:2], s}, w, d);
            host.bus(1'b0, 1'b0, 1'b1, SEL_ON, WR_ALL, {base[18:2], ~s}, ~d);
            idle();
            host.bus(1'b1, 1'b0, 1'b1, 3'h0, WR_NO, 19'h0, 36'h0);
            end_test("writes");
            host.sleep_req_o = 1'b1;
            repeat (8) idle();
            chk(36'h1, {35'h0, sleep_o});
            host.sleep_req_o = 1'b0;
            repeat (8) idle();
            chk(36'h0, {35'h0, sleep_o});
            end_test("sleep");
            s = 2'(xs());
            step = 2'h0;
            adr = {base[18:2], s};
            host.bus(1'b0, 1'b1, 1'b1, SEL_ON, WR_NO, adr, 36'h0);
            chk(36'h1, {35'h0, oe_n});
            for (int i = 0; i < 5; i++)
            begin
                prev = adr;
                if (i != 1)
                    step++;
                nxt = order ? (s ^ step) : (s + step);
                adr = {base[18:2], nxt};
                host.bus(1'b1, 1'b1, i == 1, 3'h5, WR_NO, 19'h0, 36'h0);
                rd_out(prev);
            end
            end_test("burst");
            oe_pin = 1'b1;
            repeat (6) idle();
            chk(36'h1, {35'h0, oe_n});
            oe_pin = 1'b0;
            repeat (6) idle();
            rd_out(adr);
            for (int k = 0; k < 3; k++)
            begin
                host.bus(1'b1, 1'b0, 1'b1, bad[k], WR_NO, 19'h0, 36'h0);
                rd_out(adr);
                idle();
                chk(36'h1, {35'h0, oe_n});
                host.bus(1'b0, 1'b1, 1'b1, SEL_ON, WR_NO, adr, 36'h0);
                chk(36'h1, {35'h0, oe_n});
                idle();
                rd_out(adr);
            end
            end_test("deselect");
        end
        complete_run();
    end

    task automatic end_test(input string n);
        $display("test %s done", n);
    endtask : end_test
endmodule : pipelined_burst_sram_interface_test

`default_nettype wire
